// ### design/can_comm_state_monitor.sv
// CAN error confinement state monitor with status word and timestamps
// Operation
// - Error Active while both counters below 128
// - Error Passive when a counter exceeds 127
// - No transmit count on ack errors when passive
// - Bus Off above 255 stops communication at once
// - Bus Off held until host restart
// - Init after reset, no communication
// - Start moves Init to Error Active
// - Stop returns Active or Passive to Init
// - Bit 4 mirrors transceiver error pin
// - Bit 5 shows sleep state
// - Bits 8-11 hold last frame result
// - Bit errors outside arbitration coded 4, 5
// - CRC mismatch coded 6
// - Unacknowledged transmissions retried indefinitely
// - Transmit counter bits 16-23, starts at zero
// - Receive counter bits 24-31, starts at zero
// - Transmit counter invalid once Bus Off
// - Start time in 100 ns ticks, else 0
// - Communication begin time, else 0
// - Armed trigger captures both timestamps atomically
`timescale 1ns/1ps
`include "can_state_map.svh"
module can_comm_state_monitor
(
    // Clock, reset, enable
    input  wire logic                                   mclk,
    input  wire logic                                   rst,
    input  wire logic                                   ce,
    // Host commands
    input  wire can_state_pkg::host_cmd_t               host_cmd,
    // Protocol controller report
    input  wire can_state_pkg::frame_event_t            frame_event,
    // Pins
    input  wire logic                                   transceiver_error_input,
    input  wire logic                                   sleep_input,
    input  wire logic                                   time_trigger_input,
    // Time trigger
    input  wire logic                                   trigger_arm,
    input  wire logic [63:0]                            network_time,
    // State read
    output logic [31:0]                                 can_comm_state_word,
    output logic [63:0]                                 interface_start_time,
    output logic [63:0]                                 comm_begin_time,
    output can_state_pkg::trigger_timestamp_pair_t      trigger_timestamp_pair,
    output logic                                        trigger_valid,
    // Protocol controller control
    output logic                                        comm_enable,
    output logic                                        tx_retry
);
    import can_state_pkg::*;

    localparam int TICK_CNT = `TICK_CYCLES;

    typedef struct packed {
        comm_state_t             state;
        logic                    xerr_s1;
        logic                    xerr_s2;
        logic                    sleep_s1;
        logic                    sleep_s2;
        logic                    trig_s1;
        logic                    trig_s2;
        logic                    trig_prev;
        logic [7:0]              tick_cnt;
        logic [63:0]             local_time;
        last_err_t               last_err;
        logic [63:0]             start_time;
        logic [63:0]             comm_time;
        logic                    comm_seen;
        logic                    armed;
        logic                    trig_valid;
        trigger_timestamp_pair_t trig_pair;
        logic                    comm_en;
        logic                    retry;
        logic [31:0]             word;
    } mon_state_t;

    mon_state_t cur;
    mon_state_t nxt;

    logic                  communicating;
    logic                  start_go;
    logic                  stop_go;
    logic                  counted;
    logic                  skip_bit;
    logic                  ack_err;
    logic                  trig_rise;
    logic [1:0]            cnt_err;
    logic [1:0]            cnt_ok;
    logic [`CNT_WIDTH-1:0] cnt_q    [2];
    logic [`CNT_WIDTH-1:0] cnt_next [2];
    logic [7:0]            tec_field;
    logic [7:0]            rec_field;

    function automatic logic [3:0] state_code(input comm_state_t s);
        case (s)
            ST_ERR_ACTIVE:  state_code = `COMM_CODE_ACTIVE;
            ST_ERR_PASSIVE: state_code = `COMM_CODE_PASSIVE;
            ST_BUS_OFF:     state_code = `COMM_CODE_BUS_OFF;
            default:        state_code = `COMM_CODE_INIT;
        endcase
    endfunction

    // Index 0 is the transmit counter, index 1 the receive counter
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_cnt
            localparam int STEP = (gi == 0) ? `TEC_ERR_STEP : `REC_ERR_STEP;
            err_counter #(
                .WIDTH    (`CNT_WIDTH),
                .ERR_STEP (STEP),
                .OK_STEP  (`OK_STEP)
            ) err_counter_i (
                .mclk       (mclk),
                .rst        (rst),
                .ce         (ce),
                .clear      (start_go),
                .err        (cnt_err[gi]),
                .ok         (cnt_ok[gi]),
                .count      (cnt_q[gi]),
                .next_count (cnt_next[gi])
            );
        end
    endgenerate

    always_comb begin
        nxt           = cur;
        communicating = (cur.state == ST_ERR_ACTIVE) || (cur.state == ST_ERR_PASSIVE);
        start_go      = host_cmd.start && ((cur.state == ST_INIT) || (cur.state == ST_BUS_OFF));
        stop_go       = host_cmd.stop && communicating;
        counted       = frame_event.done && communicating;
        // Bit errors in arbitration are lost arbitration, not faults
        skip_bit      = frame_event.in_arb &&
                        ((frame_event.code == LE_BIT1) || (frame_event.code == LE_BIT0));
        ack_err       = !frame_event.ok && (frame_event.code == LE_ACK);
        cnt_err[0]    = counted && frame_event.is_tx && !frame_event.ok && !skip_bit &&
                        !((cur.state == ST_ERR_PASSIVE) && ack_err);
        cnt_ok[0]     = counted && frame_event.is_tx && frame_event.ok;
        cnt_err[1]    = counted && !frame_event.is_tx && !frame_event.ok && !skip_bit;
        cnt_ok[1]     = counted && !frame_event.is_tx && frame_event.ok;

        // Pin synchronisers
        nxt.xerr_s1   = transceiver_error_input;
        nxt.xerr_s2   = cur.xerr_s1;
        nxt.sleep_s1  = sleep_input;
        nxt.sleep_s2  = cur.sleep_s1;
        nxt.trig_s1   = time_trigger_input;
        nxt.trig_s2   = cur.trig_s1;
        nxt.trig_prev = cur.trig_s2;
        trig_rise     = cur.trig_s2 && !cur.trig_prev;

        // Free-running 100 ns time base
        if (cur.tick_cnt == 8'(TICK_CNT - 1)) begin
            nxt.tick_cnt   = 8'h00;
            nxt.local_time = cur.local_time + 64'h1;
        end else begin
            nxt.tick_cnt   = cur.tick_cnt + 8'h01;
        end

        if (counted && !skip_bit) begin
            nxt.last_err = frame_event.ok ? LE_NONE : frame_event.code;
        end

        // First frame activity after startup marks communication begin
        if (counted && !cur.comm_seen) begin
            nxt.comm_seen = 1'b1;
            nxt.comm_time = cur.local_time;
        end

        case (cur.state)
            ST_INIT: begin
                if (start_go) begin
                    nxt.state      = ST_ERR_ACTIVE;
                    nxt.start_time = cur.local_time;
                    nxt.comm_seen  = 1'b0;
                    nxt.comm_time  = `TIME_INVALID;
                end
            end
            ST_ERR_ACTIVE, ST_ERR_PASSIVE: begin
                if (stop_go) begin
                    nxt.state      = ST_INIT;
                    nxt.start_time = `TIME_INVALID;
                    nxt.comm_time  = `TIME_INVALID;
                    nxt.comm_seen  = 1'b0;
                end else if (cnt_next[0] > `CNT_WIDTH'(`BUS_OFF_LIMIT)) begin
                    nxt.state      = ST_BUS_OFF;
                    nxt.comm_time  = `TIME_INVALID;
                end else if ((cnt_next[0] > `CNT_WIDTH'(`PASSIVE_LIMIT)) ||
                             (cnt_next[1] > `CNT_WIDTH'(`PASSIVE_LIMIT))) begin
                    nxt.state      = ST_ERR_PASSIVE;
                end else begin
                    nxt.state      = ST_ERR_ACTIVE;
                end
            end
            ST_BUS_OFF: begin
                // Only a host restart leaves Bus Off
                if (start_go) begin
                    nxt.state      = ST_ERR_ACTIVE;
                    nxt.start_time = cur.local_time;
                    nxt.comm_seen  = 1'b0;
                    nxt.comm_time  = `TIME_INVALID;
                end
            end
            default: begin
                nxt.state = ST_INIT;
            end
        endcase

        // Trigger capture: both halves written in one cycle
        if (trigger_arm) begin
            nxt.armed      = 1'b1;
            nxt.trig_valid = 1'b0;
        end else if (cur.armed && trig_rise) begin
            nxt.armed                  = 1'b0;
            nxt.trig_valid             = 1'b1;
            nxt.trig_pair.local_time   = cur.local_time;
            nxt.trig_pair.network_time = network_time;
        end

        nxt.comm_en = (nxt.state == ST_ERR_ACTIVE) || (nxt.state == ST_ERR_PASSIVE);
        nxt.retry   = counted && frame_event.is_tx && ack_err && nxt.comm_en;

        tec_field = (nxt.state == ST_BUS_OFF) ? `TEC_INVALID : cnt_next[0][7:0];
        rec_field = (cnt_next[1] > `CNT_WIDTH'(`BUS_OFF_LIMIT)) ? 8'hFF : cnt_next[1][7:0];
        nxt.word  = 32'h0000_0000;
        nxt.word[`FLD_STATE_LSB +: 4]    = state_code(nxt.state);
        nxt.word[`FLD_XCVR_ERR_BIT]      = cur.xerr_s2;
        nxt.word[`FLD_SLEEP_BIT]         = cur.sleep_s2;
        nxt.word[`FLD_LAST_ERR_LSB +: 4] = nxt.last_err;
        nxt.word[`FLD_TEC_LSB +: 8]      = tec_field;
        nxt.word[`FLD_REC_LSB +: 8]      = rec_field;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cur       <= '0;
            cur.state <= ST_INIT;
            cur.word  <= `STATE_WORD_RESET;
        end else if (ce) begin
            cur <= nxt;
        end
    end

    assign can_comm_state_word    = cur.word;
    assign interface_start_time   = cur.start_time;
    assign comm_begin_time        = cur.comm_time;
    assign trigger_timestamp_pair = cur.trig_pair;
    assign trigger_valid          = cur.trig_valid;
    assign comm_enable            = cur.comm_en;
    assign tx_retry               = cur.retry;

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_init_start;
        ce && (cur.state == ST_INIT) && host_cmd.start;
    endsequence

    sequence s_comm_stop;
        ce && communicating && host_cmd.stop;
    endsequence

    sequence s_tec_over;
        ce && communicating && !host_cmd.stop && (cnt_next[0] > 9'h0FF);
    endsequence

    active_limits_a: assert property ((cur.state == ST_ERR_ACTIVE) |->
        (cnt_q[0] < 9'h080) && (cnt_q[1] < 9'h080))
        else $error("error active with a counter at 128 or more");

    passive_entry_a: assert property (ce && communicating && !host_cmd.stop &&
        (cnt_next[0] <= 9'h0FF) && ((cnt_next[0] > 9'h07F) || (cnt_next[1] > 9'h07F)) |=>
        (cur.state == ST_ERR_PASSIVE) && (cur.word[3:0] == 4'h1))
        else $error("error count above 127 did not give error passive");

    passive_ack_a: assert property (ce && (cur.state == ST_ERR_PASSIVE) && frame_event.done &&
        frame_event.is_tx && ack_err && !host_cmd.stop |=> cnt_q[0] == $past(cnt_q[0]))
        else $error("ack error raised transmit count while passive");

    bus_off_a: assert property (s_tec_over |=> (cur.state == ST_BUS_OFF) && !comm_enable &&
        (cur.word[23:16] == 8'hFF))
        else $error("transmit count above 255 did not stop communication");

    bus_off_hold_a: assert property (ce && (cur.state == ST_BUS_OFF) && !host_cmd.start |=>
        (cur.state == ST_BUS_OFF))
        else $error("bus off left without a restart");

    init_power_a: assert property ((cur.state == ST_INIT) |->
        !comm_enable && (interface_start_time == 64'h0))
        else $error("init state with communication or a start time");

    start_move_a: assert property (s_init_start |=> (cur.state == ST_ERR_ACTIVE) &&
        (cnt_q[0] == 9'h000) && (cnt_q[1] == 9'h000) ##0 comm_enable)
        else $error("start did not enter error active with clear counters");

    stop_move_a: assert property (s_comm_stop |=> (cur.state == ST_INIT) &&
        (comm_begin_time == 64'h0))
        else $error("stop did not return to init");

    retry_pulse_a: assert property (ce && communicating && frame_event.done && frame_event.is_tx &&
        ack_err && !host_cmd.stop && (cnt_next[0] <= 9'h0FF) |=> tx_retry)
        else $error("unacknowledged frame not retried");

    last_err_a: assert property (ce && communicating && frame_event.done && !frame_event.ok &&
        (frame_event.code == LE_CRC) |=> cur.word[11:8] == 4'h6)
        else $error("crc error not reported");

    trig_capture_a: assert property (ce && !trigger_arm && cur.armed && trig_rise |=>
        trigger_valid && (trigger_timestamp_pair.local_time == $past(cur.local_time)) &&
        (trigger_timestamp_pair.network_time == $past(network_time)))
        else $error("armed trigger edge not captured");

    pin_mirror_a: assert property (ce |=> cur.word[4] == $past(cur.xerr_s2))
        else $error("transceiver error bit does not follow pin");

endmodule // can_comm_state_monitor

// ### design/can_state_map.svh
// Field positions, codes, thresholds and timing counts of the CAN state monitor
`ifndef CAN_STATE_MAP_SVH
`define CAN_STATE_MAP_SVH

// Status word field positions
`define FLD_STATE_LSB      0
`define FLD_XCVR_ERR_BIT   4
`define FLD_SLEEP_BIT      5
`define FLD_LAST_ERR_LSB   8
`define FLD_TEC_LSB        16
`define FLD_REC_LSB        24

// Communication state codes
`define COMM_CODE_ACTIVE   4'h0
`define COMM_CODE_PASSIVE  4'h1
`define COMM_CODE_BUS_OFF  4'h2
`define COMM_CODE_INIT     4'h3

// Error confinement thresholds and weights
`define PASSIVE_LIMIT      127
`define BUS_OFF_LIMIT      255
`define TEC_ERR_STEP       8
`define REC_ERR_STEP       1
`define OK_STEP            1
`define CNT_WIDTH          9

// Reset and invalid values
`define STATE_WORD_RESET   32'h0000_0003
`define TEC_INVALID        8'hFF
`define TIME_INVALID       64'h0000_0000_0000_0000

// Timestamp tick
`define TICK_TIME_NS       100
`define MCLK_PERIOD_NS     50
`define TICK_CYCLES        ((`TICK_TIME_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

`endif

// ### design/can_state_pkg.sv
// Types shared by the CAN communication state monitor
package can_state_pkg;

    typedef enum logic [3:0] {
        ST_ERR_ACTIVE  = 4'b0001,
        ST_ERR_PASSIVE = 4'b0010,
        ST_BUS_OFF     = 4'b0100,
        ST_INIT        = 4'b1000
    } comm_state_t;

    typedef enum logic [3:0] {
        LE_NONE  = 4'h0,
        LE_STUFF = 4'h1,
        LE_FORM  = 4'h2,
        LE_ACK   = 4'h3,
        LE_BIT1  = 4'h4,
        LE_BIT0  = 4'h5,
        LE_CRC   = 4'h6
    } last_err_t;

    // One-cycle report of a finished receive or transmit attempt
    typedef struct packed {
        logic      done;
        logic      is_tx;
        logic      ok;
        logic      in_arb;
        last_err_t code;
    } frame_event_t;

    typedef struct packed {
        logic start;
        logic stop;
    } host_cmd_t;

    typedef struct packed {
        logic [63:0] local_time;
        logic [63:0] network_time;
    } trigger_timestamp_pair_t;

endpackage

// ### design/err_counter.sv
// Saturating weighted error counter with a look-ahead of its next value
`timescale 1ns/1ps
`include "can_state_map.svh"
module err_counter #(
    parameter int WIDTH    = `CNT_WIDTH,
    parameter int ERR_STEP = `TEC_ERR_STEP,
    parameter int OK_STEP  = `OK_STEP
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             ce,
    // Events
    input  wire logic             clear,
    input  wire logic             err,
    input  wire logic             ok,
    // Count
    output logic [WIDTH-1:0]      count,
    output logic [WIDTH-1:0]      next_count
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
    } cnt_state_t;

    localparam logic [WIDTH:0] MAX_CNT = {1'b0, {WIDTH{1'b1}}};

    cnt_state_t cur;
    cnt_state_t nxt;
    logic [WIDTH:0] sum;

    always_comb begin
        nxt = cur;
        sum = {1'b0, cur.count} + WIDTH'(ERR_STEP);
        if (clear) begin
            nxt.count = '0;
        end else if (err) begin
            // Saturate so a stuck bus cannot wrap the count back to zero
            nxt.count = (sum > MAX_CNT) ? MAX_CNT[WIDTH-1:0] : sum[WIDTH-1:0];
        end else if (ok && (cur.count >= WIDTH'(OK_STEP))) begin
            nxt.count = cur.count - WIDTH'(OK_STEP);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cur <= '0;
        end else if (ce) begin
            cur <= nxt;
        end
    end

    assign count      = cur.count;
    assign next_count = nxt.count;

endmodule // err_counter

// ### testbench/can_node_model.sv
// Behavioural protocol controller reporting frame results from the CAN bus
`timescale 1ns/1ps
module can_node_model
(
    // Clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rst,
    // Bench command
    input  wire logic                        send,
    input  wire can_state_pkg::frame_event_t ev_req,
    // Report to the monitor
    output can_state_pkg::frame_event_t      frame_event
);
    import can_state_pkg::*;

    frame_event_t next_event;

    // Idle fields toggle so the monitor cannot lean on stale values
    always_comb begin
        next_event      = ~frame_event;
        next_event.done = 1'b0;
        if (send) begin
            next_event = ev_req;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            frame_event <= '0;
        end else begin
            frame_event <= next_event;
        end
    end
endmodule // can_node_model

// ### testbench/can_comm_state_monitor_tb.sv
// Self-checking bench for the CAN communication state monitor
`timescale 1ns/1ps
`include "can_state_map.svh"
module can_comm_state_monitor_tb;
    import can_state_pkg::*;
    logic                    mclk;
    logic                    rst;
    host_cmd_t               host_cmd;
    frame_event_t            ev_req;
    frame_event_t            frame_event;
    logic                    send;
    logic                    ce;
    logic                    xcvr_err;
    logic                    sleep_pin;
    logic                    trig_pin;
    logic                    trigger_arm;
    logic [63:0]             network_time;
    logic [31:0]             word;
    logic [63:0]             start_time;
    logic [63:0]             begin_time;
    trigger_timestamp_pair_t pair;
    logic                    trigger_valid;
    logic                    comm_enable;
    logic                    tx_retry;
    int                      error_cnt = 0;
    int                      num_checks = 0;

    can_node_model can_node_model_i (.mclk(mclk), .rst(rst), .send(send), .ev_req(ev_req),
        .frame_event(frame_event));

    can_comm_state_monitor can_comm_state_monitor_i (
        .mclk(mclk), .rst(rst), .ce(ce), .host_cmd(host_cmd), .frame_event(frame_event),
        .transceiver_error_input(xcvr_err), .sleep_input(sleep_pin),
        .time_trigger_input(trig_pin), .trigger_arm(trigger_arm), .network_time(network_time),
        .can_comm_state_word(word), .interface_start_time(start_time),
        .comm_begin_time(begin_time), .trigger_timestamp_pair(pair),
        .trigger_valid(trigger_valid), .comm_enable(comm_enable), .tx_retry(tx_retry));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // Command is {start, stop}
    task automatic cmd(input logic [1:0] c);
        @(posedge mclk) host_cmd <= c;
        @(posedge mclk) host_cmd <= '0;
        #1;
    endtask

    // Returns just after the monitor has taken the report
    task automatic ev(input logic tx, input logic ok, input logic arb, input last_err_t code);
        @(posedge mclk) begin
            send   <= 1'b1;
            ev_req <= '{1'b1, tx, ok, arb, code};
        end
        @(posedge mclk) send <= 1'b0;
        @(posedge mclk);
        #1;
    endtask

    task automatic t_reset;
        chk(word, `STATE_WORD_RESET);
        chk(comm_enable, 1'b0);
        chk(start_time, `TIME_INVALID);
        chk(begin_time, `TIME_INVALID);
        ev(1'b0, 1'b0, 1'b0, LE_CRC);
        chk(word, `STATE_WORD_RESET);
        $display("t_reset done");
    endtask

    task automatic t_start;
        cmd(2'b10);
        chk(word[3:0], `COMM_CODE_ACTIVE);
        chk(comm_enable, 1'b1);
        chk(word[31:16], 16'h0000);
        repeat (4) @(posedge mclk);
        #1;
        chk(start_time != 64'h0, 1'b1);
        chk(begin_time, `TIME_INVALID);
        $display("t_start done");
    endtask

    task automatic t_codes;
        for (int i = 1; i <= 6; i++) begin
            ev(1'b1, 1'b0, 1'b0, last_err_t'(i));
            chk(word[11:8], i);
            chk(tx_retry, i == 3);
            chk(word[23:16], `TEC_ERR_STEP * i);
        end
        ev(1'b1, 1'b1, 1'b0, LE_NONE);
        chk(word[23:8], {8'd47, 8'h00});
        // Bit errors during arbitration are ordinary lost arbitration
        ev(1'b1, 1'b0, 1'b1, LE_BIT1);
        chk(word[23:8], {8'd47, 8'h00});
        chk(begin_time != 64'h0, 1'b1);
        $display("t_codes done");
    endtask

    task automatic t_rx;
        ev(1'b0, 1'b0, 1'b0, LE_CRC);
        chk(word[31:24], 8'd1);
        ev(1'b0, 1'b1, 1'b0, LE_NONE);
        ev(1'b0, 1'b1, 1'b0, LE_NONE);
        chk(word[31:24], 8'd0);
        $display("t_rx done");
    endtask

    // Clock enable low must swallow a report; word is active, TEC 47, REC 0
    task automatic t_hold;
        @(posedge mclk) ce <= 1'b0;
        ev(1'b1, 1'b0, 1'b0, LE_FORM);
        chk(word, 32'h002F_0000);
        @(posedge mclk) ce <= 1'b1;
        @(posedge mclk);
        #1;
        chk(word, 32'h002F_0000);
        $display("t_hold done");
    endtask

    task automatic t_passive;
        repeat (10) ev(1'b1, 1'b0, 1'b0, LE_FORM);
        chk(word[23:16], 8'd127);
        chk(word[3:0], `COMM_CODE_ACTIVE);
        ev(1'b1, 1'b0, 1'b0, LE_FORM);
        chk(word[3:0], `COMM_CODE_PASSIVE);
        chk(comm_enable, 1'b1);
        ev(1'b1, 1'b0, 1'b0, LE_ACK);
        chk(word[23:8], {8'd135, 8'h03});
        chk(tx_retry, 1'b1);
        $display("t_passive done");
    endtask

    task automatic t_bus_off;
        repeat (15) ev(1'b1, 1'b0, 1'b0, LE_STUFF);
        chk({word[23:16], word[3:0]}, {8'd255, `COMM_CODE_PASSIVE});
        ev(1'b1, 1'b0, 1'b0, LE_STUFF);
        chk(word[3:0], `COMM_CODE_BUS_OFF);
        chk(comm_enable, 1'b0);
        chk(word[23:16], `TEC_INVALID);
        cmd(2'b01);
        ev(1'b0, 1'b0, 1'b0, LE_CRC);
        chk(word[3:0], `COMM_CODE_BUS_OFF);
        cmd(2'b10);
        chk(word[3:0], `COMM_CODE_ACTIVE);
        chk(word[31:16], 16'h0000);
        $display("t_bus_off done");
    endtask

    task automatic t_pins;
        @(posedge mclk) begin
            xcvr_err  <= 1'b1;
            sleep_pin <= 1'b1;
        end
        repeat (4) @(posedge mclk);
        #1;
        chk(word[5:4], 2'b11);
        @(posedge mclk) xcvr_err <= 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        chk(word[5:4], 2'b10);
        $display("t_pins done");
    endtask

    task automatic t_trigger;
        int n;
        n = 0;
        @(posedge mclk) begin
            trigger_arm  <= 1'b1;
            network_time <= 64'h0123_4567_89AB_CDEF;
        end
        @(posedge mclk) begin
            trigger_arm <= 1'b0;
            trig_pin    <= 1'b1;
        end
        while (trigger_valid !== 1'b1 && n < 10) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk(trigger_valid, 1'b1);
        chk(pair.network_time, 64'h0123_4567_89AB_CDEF);
        chk(pair.local_time != 64'h0, 1'b1);
        // A later edge must not overwrite the first capture
        @(posedge mclk) begin
            network_time <= 64'h0000_0000_0000_0055;
            trig_pin     <= 1'b0;
        end
        repeat (3) @(posedge mclk);
        trig_pin <= 1'b1;
        repeat (6) @(posedge mclk);
        #1;
        chk(pair.network_time, 64'h0123_4567_89AB_CDEF);
        $display("t_trigger done");
    endtask

    task automatic t_stop;
        cmd(2'b01);
        chk(word[3:0], `COMM_CODE_INIT);
        chk(comm_enable, 1'b0);
        chk(start_time, `TIME_INVALID);
        chk(begin_time, `TIME_INVALID);
        $display("t_stop done");
    endtask

    initial begin
        rst          = 1'b1;
        host_cmd     = '0;
        send         = 1'b0;
        ce           = 1'b1;
        ev_req       = '0;
        xcvr_err     = 1'b0;
        sleep_pin    = 1'b0;
        trig_pin     = 1'b0;
        trigger_arm  = 1'b0;
        network_time = 64'h0;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
        t_reset();
        t_start();
        t_codes();
        t_rx();
        t_hold();
        t_passive();
        t_bus_off();
        t_pins();
        t_trigger();
        t_stop();
        end_of_test();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        #(50 * 3000);
        error_cnt++;
        end_of_test();
    end
endmodule // can_comm_state_monitor_tb
